/* File: logic/pts_defines.svh */
// Summary of operation
// R01: Count register read/write, zero on reset
// R02: Input divider select: 00 /1, 01 /4, 1x /16
// R03: Count to period, then zero next increment
// R04: Period register read/write, all ones on reset
// R05: Postscaler 1..16 sets match flag bit 1
// R06: Postscale ratio is field value plus one
// R07: Timer runs only while run bit set
// R08: Writes to count or control clear scalers
// R09: Control write leaves count unchanged
// R10: Unscaled match pulse goes to serial port
// R11: Count and match form PWM time base
// R12: Control bit 7 reads zero, resets zero
// R13: PWM period excludes the postscaler
// R14: Software clears the match flag itself
//
// Constants of the period timer: offsets, reset values, bit
// positions, prescaler limits and the instruction-clock divider.
// Assumes an 8-bit register port and one core clock.
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PTS_ADDR_FLAGS 8'h0c
`define PTS_ADDR_COUNT 8'h11
`define PTS_ADDR_CTRL 8'h12
`define PTS_ADDR_ENABLES 8'h8c
`define PTS_ADDR_PERIOD 8'h92

// ----------------------------------------------------------------
// Reset values and bit positions
// ----------------------------------------------------------------
`define PTS_RST_COUNT 8'h00
`define PTS_RST_PERIOD 8'hff
`define PTS_RST_CTRL 7'h00
`define PTS_BIT_MATCH 1

// ----------------------------------------------------------------
// Timing: core clock period and instruction-clock divider
// ----------------------------------------------------------------
`define PTS_CLK_PERIOD_NS 10
`define PTS_INSTR_DIV 4
`define PTS_PRE_LIM_1 4'h0
`define PTS_PRE_LIM_4 4'h3
`define PTS_PRE_LIM_16 4'hf

`endif

/* File: logic/pts_pkg.sv */
// Types shared by the period timer and its scaler counters.
// Assumes the constants header is compiled alongside.
package pts_pkg;

    // Control register fields, bit 6 down to bit 0
    typedef struct packed {
        logic [3:0] output_divider_select;
        logic tick_run_enable;
        logic [1:0] input_divider_select;
    } pts_ctrl_t;

    // Register port request from the master
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pts_bus_req_t;

    // Time base offered to the PWM units
    typedef struct packed {
        logic [7:0] count;
        logic match;
    } pts_pwm_base_t;

    // Whole state of the timer top
    typedef struct packed {
        logic [7:0] tick_count;
        logic [7:0] period_limit;
        pts_ctrl_t ctrl;
        logic period_match_flag;
        logic period_match_irq_enable;
        logic match;
        logic [7:0] rd_data;
        logic irq;
    } pts_state_t;

endpackage

/* File: logic/pts_scaler.sv */
// Modulo counter giving one pulse every limit+1 ticks.
// Assumes tick and clr are synchronous one-cycle enables.
`timescale 1ns/100ps
`default_nettype none

module pts_scaler
    import pts_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic tick,
    input wire logic [WIDTH-1:0] limit,
    output logic pulse
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } pts_scl_state_t;

    pts_scl_state_t s_q;
    pts_scl_state_t s_d;

    // Next count; clear wins over a tick
    always_comb begin
        s_d = s_q;
        pulse = 1'b0;
        if (clr) begin
            s_d.cnt = '0;
        end else if (tick) begin
            // Greater-or-equal copes with a lowered limit
            if (s_q.cnt >= limit) begin
                s_d.cnt = '0;
                pulse = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

/* File: logic/pts_timer.sv */
// Eight-bit period timer with input prescaler and output
// postscaler, an interrupt flag and mask, a register port.
// Assumes synchronous inputs, one core clock and a master
// that never strobes read and write together.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

`include "pts_defines.svh"

module pts_timer
    import pts_pkg::*;
#(
    parameter int INSTR_DIV = `PTS_INSTR_DIV
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire pts_bus_req_t bus_req,
    output logic [7:0] rd_data,
    output logic irq,
    output logic ssp_shift_tick,
    output pts_pwm_base_t pwm_base
);

    // ----------------------------------------------------------------
    // Local constants
    // ----------------------------------------------------------------

    // Instruction clock divider limit, two bits wide
    localparam logic [1:0] INSTR_LIM = 2'(INSTR_DIV - 1);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------

    pts_state_t s_q;
    pts_state_t s_d;

    logic hit_flags;
    logic hit_count;
    logic hit_ctrl;
    logic hit_enables;
    logic hit_period;

    logic wr_flags;
    logic wr_count;
    logic wr_ctrl;
    logic wr_enables;
    logic wr_period;
    logic rd_flags;

    logic scl_clr;
    logic instr_tick;
    logic pre_in;
    logic pre_tick;
    logic match_now;
    logic post_tick;
    logic [3:0] pre_limit;
    logic [7:0] count_inc;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------

    // One hit line per mapped offset
    assign hit_flags = (bus_req.addr == `PTS_ADDR_FLAGS);
    assign hit_count = (bus_req.addr == `PTS_ADDR_COUNT);
    assign hit_ctrl = (bus_req.addr == `PTS_ADDR_CTRL);
    assign hit_enables = (bus_req.addr == `PTS_ADDR_ENABLES);
    assign hit_period = (bus_req.addr == `PTS_ADDR_PERIOD);

    // Qualified strobes
    assign wr_flags = bus_req.wr & hit_flags;
    assign wr_count = bus_req.wr & hit_count;
    assign wr_ctrl = bus_req.wr & hit_ctrl;
    assign wr_enables = bus_req.wr & hit_enables;
    assign wr_period = bus_req.wr & hit_period;
    assign rd_flags = bus_req.rd & hit_flags;

    // ----------------------------------------------------------------
    // Clock chain: instruction clock, prescaler, postscaler
    // ----------------------------------------------------------------

    // Scaler clear on count or control write
    assign scl_clr = wr_count | wr_ctrl; // R08

    // Instruction clock is core clock divided by INSTR_DIV, four by default
    pts_scaler #(
        .WIDTH(2)
    ) u_instr_div (
        .core_clk(core_clk),
        .rst(rst),
        .clr(1'b0),
        .tick(1'b1),
        .limit(INSTR_LIM),
        .pulse(instr_tick)
    );

    // Input divider limit from select field
    always_comb begin
        case (s_q.ctrl.input_divider_select) // R02
            2'b00: pre_limit = `PTS_PRE_LIM_1;
            2'b01: pre_limit = `PTS_PRE_LIM_4;
            default: pre_limit = `PTS_PRE_LIM_16;
        endcase
    end

    // Prescaler is fed only while running
    assign pre_in = instr_tick & s_q.ctrl.tick_run_enable; // R07

    // Input prescaler
    pts_scaler #(
        .WIDTH(4)
    ) u_pre_div (
        .core_clk(core_clk),
        .rst(rst),
        .clr(scl_clr),
        .tick(pre_in),
        .limit(pre_limit),
        .pulse(pre_tick)
    );

    // Period match: count equals period on an increment
    assign match_now = pre_tick & ~wr_count
        & (s_q.tick_count == s_q.period_limit); // R03

    // Plain increment of the count
    assign count_inc = s_q.tick_count + 8'h01;

    // Output postscaler, ratio is field plus one
    pts_scaler #(
        .WIDTH(4)
    ) u_post_div (
        .core_clk(core_clk),
        .rst(rst),
        .clr(scl_clr),
        .tick(match_now),
        .limit(s_q.ctrl.output_divider_select), // R06
        .pulse(post_tick)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------

    always_comb begin
        s_d = s_q;
        s_d.match = 1'b0;
        s_d.rd_data = 8'h00;

        // Count: software write beats an increment
        if (wr_count) begin
            s_d.tick_count = bus_req.wdata; // R01
        end else if (pre_tick) begin
            if (match_now) begin
                s_d.tick_count = `PTS_RST_COUNT; // R03
            end else begin
                s_d.tick_count = count_inc;
            end
        end

        // Unscaled match pulse for serial port and PWM
        s_d.match = match_now; // R10 R13

        // Period register
        if (wr_period) begin
            s_d.period_limit = bus_req.wdata; // R04
        end

        // Control write keeps the count
        if (wr_ctrl) begin
            s_d.ctrl = pts_ctrl_t'(bus_req.wdata[6:0]); // R09 R12
        end

        // Interrupt mask
        if (wr_enables) begin
            s_d.period_match_irq_enable =
                bus_req.wdata[`PTS_BIT_MATCH];
        end

        // Flag: written or read-cleared by software
        if (wr_flags) begin
            s_d.period_match_flag = bus_req.wdata[`PTS_BIT_MATCH]; // R14
        end else if (rd_flags) begin
            s_d.period_match_flag = 1'b0; // R14
        end

        // Postscaler output sets flag; set wins over clear
        if (post_tick) begin
            s_d.period_match_flag = 1'b1; // R05
        end

        // Level interrupt from unmasked flag
        s_d.irq = s_d.period_match_flag
            & s_d.period_match_irq_enable;

        // Read data, valid the cycle after the strobe
        if (bus_req.rd) begin
            case (bus_req.addr)
                `PTS_ADDR_FLAGS: begin
                    s_d.rd_data[`PTS_BIT_MATCH] =
                        s_q.period_match_flag;
                end
                `PTS_ADDR_COUNT: begin
                    s_d.rd_data = s_q.tick_count; // R01
                end
                `PTS_ADDR_CTRL: begin
                    s_d.rd_data = {1'b0, s_q.ctrl}; // R12
                end
                `PTS_ADDR_ENABLES: begin
                    s_d.rd_data[`PTS_BIT_MATCH] =
                        s_q.period_match_irq_enable;
                end
                `PTS_ADDR_PERIOD: begin
                    s_d.rd_data = s_q.period_limit; // R04
                end
                default: begin
                    s_d.rd_data = 8'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // Reset clears count, control, flags; period all ones
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.tick_count <= `PTS_RST_COUNT; // R01
            s_q.period_limit <= `PTS_RST_PERIOD; // R04
            s_q.ctrl <= pts_ctrl_t'(`PTS_RST_CTRL); // R12
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, straight from flip-flops
    // ----------------------------------------------------------------

    assign rd_data = s_q.rd_data;
    assign irq = s_q.irq;
    assign ssp_shift_tick = s_q.match; // R10

    // Time base for the PWM units
    assign pwm_base = '{count: s_q.tick_count, match: s_q.match}; // R11 R13

endmodule

`default_nettype wire

/* File: bench/pts_props.sv */
// Port checker of the period timer.
// Assumes it is bound onto pts_timer, one clock domain.
`timescale 1ns/100ps
`default_nettype none

module pts_props
    import pts_pkg::*;
#(
    parameter int INSTR_DIV = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire pts_bus_req_t bus_req,
    input wire logic [7:0] rd_data,
    input wire logic irq,
    input wire logic ssp_shift_tick,
    input wire pts_pwm_base_t pwm_base
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------
    // Decodes and named steps
    // ------------------------------------------------
    wire logic wr_cnt = bus_req.wr && bus_req.addr == 8'h11;
    sequence s_flag_read;
        bus_req.rd && bus_req.addr == 8'h0c;
    endsequence
    sequence s_ctrl_read;
        bus_req.rd && bus_req.addr == 8'h12;
    endsequence
    sequence s_count_read;
        bus_req.rd && bus_req.addr == 8'h11;
    endsequence

    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    a_match_at_zero: assert property (
        ssp_shift_tick |-> pwm_base.count == 8'h00)
        else $error("match pulse with nonzero count");
    a_pwm_match_same: assert property (
        ssp_shift_tick == pwm_base.match)
        else $error("serial and pwm match differ");
    a_match_one_cycle: assert property (
        ssp_shift_tick |=> !ssp_shift_tick)
        else $error("match pulse too long");
    a_ctrl_top_zero: assert property (
        s_ctrl_read |=> !rd_data[7])
        else $error("control bit 7 read as one");
    a_count_write: assert property (
        wr_cnt |=> pwm_base.count == $past(bus_req.wdata))
        else $error("count write not taken");
    a_count_steps: assert property (
        !$past(wr_cnt) && $changed(pwm_base.count)
        |-> pwm_base.count == $past(pwm_base.count) + 8'h01
        || pwm_base.count == 8'h00)
        else $error("count jumped");
    a_flag_read_clr: assert property (
        s_flag_read |=> !irq || ssp_shift_tick)
        else $error("irq kept after flag read");
    a_irq_rise_cause: assert property (
        $rose(irq) |-> ssp_shift_tick || $past(bus_req.wr))
        else $error("irq rose without match");
    a_count_read: assert property (
        s_count_read |=> rd_data == $past(pwm_base.count))
        else $error("count read differs from time base");
endmodule

bind pts_timer pts_props #(
    .INSTR_DIV(INSTR_DIV)
) u_props (
    .core_clk(core_clk),
    .rst(rst),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .irq(irq),
    .ssp_shift_tick(ssp_shift_tick),
    .pwm_base(pwm_base)
);

`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench of the period timer.
// Assumes pts_props is bound from its own file.
`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    err_count++; $display("BAD %s exp %h got %h", n, e, g); end end

module testbench;
    import pts_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    pts_bus_req_t bus_req = '0;
    logic [7:0] rd_data;
    logic irq;
    logic ssp_shift_tick;
    pts_pwm_base_t pwm_base;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    pts_timer #(.INSTR_DIV(2)) u_dut (.core_clk(core_clk), .rst(rst),
        .bus_req(bus_req), .rd_data(rd_data), .irq(irq),
        .ssp_shift_tick(ssp_shift_tick), .pwm_base(pwm_base));

    // ------------------------------------------------
    // Clock, hang guard, verdict
    // ------------------------------------------------
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // Bus access and waits
    // ------------------------------------------------
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, e);
        acc(1'b0, a, 8'h00);
        `CHK("rd_data", e, rd_data)
    endtask
    // Edges until the next match pulse
    task automatic wait_match(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (ssp_shift_tick !== 1'b1 && n < 300);
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_regs();
        rd_chk(8'h11, 8'h00);
        rd_chk(8'h92, 8'hff);
        rd_chk(8'h12, 8'h00);
        rd_chk(8'h0c, 8'h00);
        rd_chk(8'h40, 8'h00);
        acc(1'b1, 8'h92, 8'ha5);
        rd_chk(8'h92, 8'ha5);
        acc(1'b1, 8'h12, 8'hfb);
        rd_chk(8'h12, 8'h7b);
        acc(1'b1, 8'h11, 8'h5a);
        acc(1'b1, 8'h12, 8'h7b);
        rd_chk(8'h11, 8'h5a);
        repeat (20) @(posedge core_clk);
        rd_chk(8'h11, 8'h5a);
    endtask
    // Prescale 1/4/16: first match after restart, then gap
    task automatic t_presc();
        int n;
        int d;
        acc(1'b1, 8'h92, 8'h02);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 1 : (i == 1) ? 4 : 16;
            acc(1'b1, 8'h11, 8'h00);
            acc(1'b1, 8'h12, {5'h00, 1'b1, i[1:0]});
            wait_match(n);
            `CHK("first", 1'b1, n >= 6 * d - 2 && n <= 6 * d)
            wait_match(n);
            `CHK("gap", 6 * d, n)
            `CHK("pwm count", 8'h00, pwm_base.count)
            `CHK("pwm match", 1'b1, pwm_base.match)
            acc(1'b1, 8'h12, 8'h00);
        end
    endtask
    // Postscale counts, then mask
    task automatic t_post(input logic [3:0] s, input logic en);
        int n;
        int k;
        k = 0;
        acc(1'b0, 8'h0c, 8'h00);
        acc(1'b1, 8'h8c, {6'h00, en, 1'b0});
        acc(1'b1, 8'h12, {1'b0, s, 3'h4});
        do begin
            wait_match(n);
            k++;
        end while (irq !== 1'b1 && k < 20);
        // Match spacing ignores the postscale ratio
        if (k > 1) begin
            `CHK("pwm gap", 6, n)
        end
        if (en) begin
            `CHK("posts", s + 1, k)
        end else begin
            `CHK("masked", 1'b0, irq)
        end
        acc(1'b1, 8'h12, 8'h00);
        rd_chk(8'h0c, 8'h02);
        `CHK("irq", 1'b0, irq)
        rd_chk(8'h0c, 8'h00);
    endtask
    // Reset in mid-run while counting with irq high
    task automatic t_reset();
        acc(1'b1, 8'h92, 8'h03);
        acc(1'b1, 8'h11, 8'h01);
        acc(1'b1, 8'h8c, 8'h02);
        acc(1'b1, 8'h0c, 8'h02);
        acc(1'b1, 8'h12, 8'h7c);
        `CHK("irq before reset", 1'b1, irq)
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        `CHK("irq after reset", 1'b0, irq)
        `CHK("count after reset", 8'h00, pwm_base.count)
        rd_chk(8'h11, 8'h00);
        rd_chk(8'h92, 8'hff);
        rd_chk(8'h12, 8'h00);
        rd_chk(8'h8c, 8'h00);
        rd_chk(8'h0c, 8'h00);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_presc();
        t_post(4'h0, 1'b1);
        t_post(4'h1, 1'b1);
        t_post(4'hf, 1'b1);
        t_post(4'h3, 1'b0);
        t_reset();
        end_of_test();
    end
endmodule

`default_nettype wire
